// File: rtl/drs_pkg.sv
// Constants and carrier types for the result status encoder
// Function
// R1 - Result phase presents status bytes as successive data register reads
// R2 - Termination code bits 7,6: 00 normal, 01 abnormal after start
// R3 - Termination code 10 invalid command, 11 polling abnormal termination
// R4 - Byte 0 bit 5 set when seek, relative seek or recalibrate completes
// R5 - Byte 0 bit 4 set on outer track miss or outward overstep
// R6 - Byte 0 bit 2 head address, bits 1,0 selected unit
// R7 - Byte 1 bit 7 set past final sector or no terminal count
// R8 - Byte 1 bit 5 set on CRC error in identifier or data field
// R9 - Byte 1 bit 4 set on service overrun or underrun
// R10 - Byte 1 bit 2 set when sector, identifier or sequence not found
// R11 - Byte 1 bit 1 set when write lock active during write or format
// R12 - Byte 1 bit 0 set when identifier or data mark missing
// R13 - Byte 2 bit 6 set on data mark kind mismatch for read type
// R14 - Byte 2 bit 5 set on data field CRC error
// R15 - Byte 2 bit 4 set when identifier track differs from internal track
// R16 - Byte 2 bit 1 set when mismatching identifier track equals FF
// R17 - Byte 2 bit 0 set when no data or deleted data mark found
// R18 - Unused status bits always read zero
// R19 - Fields captured at termination and held until all bytes read
package drs_pkg;
	localparam logic [1:0] TC_NORMAL   = 2'h0;
	localparam logic [1:0] TC_ABNORMAL = 2'h1;
	localparam logic [1:0] TC_INVALID  = 2'h2;
	localparam logic [1:0] TC_POLLING  = 2'h3;
	localparam logic [7:0] BAD_TRACK_ID = 8'hFF;
	localparam int B0_TC_HI = 7;
	localparam int B0_TC_LO = 6;
	localparam int B0_SEEK  = 5;
	localparam int B0_FAULT = 4;
	localparam int B0_HEAD  = 2;
	localparam int B0_UNIT_HI = 1;
	localparam int B0_UNIT_LO = 0;
	localparam int B1_END   = 7;
	localparam int B1_CRC   = 5;
	localparam int B1_SVC   = 4;
	localparam int B1_MISS  = 2;
	localparam int B1_LOCK  = 1;
	localparam int B1_MARK  = 0;
	localparam int B2_CTRL  = 6;
	localparam int B2_PCRC  = 5;
	localparam int B2_TRK   = 4;
	localparam int B2_BAD   = 1;
	localparam int B2_PMARK = 0;
	localparam logic [1:0] NUM_BYTES = 2'h3;
	localparam logic [1:0] IDX_FIRST = 2'h0;

	// Raw termination events from the command engine
	typedef struct packed {
		logic       fatal_invalid;
		logic       fatal_polling;
		logic       seek_done;
		logic       recal_no_outer;
		logic       relseek_overstep;
		logic       head;
		logic [1:0] unit_select;
		logic       past_final_sector;
		logic       rw_no_transfer_final;
		logic       id_crc_fail;
		logic       data_crc_fail;
		logic       service_late;
		logic       sector_not_found;
		logic       id_unreadable;
		logic       track_seq_fail;
		logic       write_lock_in;
		logic       write_cmd;
		logic       no_id_after_two_markers;
		logic       no_data_mark;
		logic       read_normal_cmd;
		logic       read_deleted_cmd;
		logic       saw_deleted_mark;
		logic       saw_normal_mark;
		logic [7:0] id_track;
		logic [7:0] internal_track;
	} drs_events_t;

	typedef struct packed {
		logic [7:0] first;
		logic [7:0] second;
		logic [7:0] third;
	} drs_status_t;

	typedef enum logic [1:0] {
		ST_IDLE   = 2'b01,
		ST_RESULT = 2'b10
	} drs_state_t;
endpackage

// File: rtl/drs_encode.sv
// Combinational encoding of termination events into three status bytes
`timescale 1ns/10ps
module drs_encode
(
	input  drs_pkg::drs_events_t ev,
	input  wire logic            started,
	output drs_pkg::drs_status_t st
);
	always_comb
	begin
		logic [1:0] code;
		logic       track_diff;
		logic       abnormal;
		code = drs_pkg::TC_NORMAL;
		abnormal = 1'b0;
		track_diff = (ev.id_track != ev.internal_track); // R15
		st = '0; // R18
		st.second[drs_pkg::B1_END]  = ev.past_final_sector | ev.rw_no_transfer_final; // R7
		st.second[drs_pkg::B1_CRC]  = ev.id_crc_fail | ev.data_crc_fail; // R8
		st.second[drs_pkg::B1_SVC]  = ev.service_late; // R9
		st.second[drs_pkg::B1_MISS] = ev.sector_not_found | ev.id_unreadable | ev.track_seq_fail; // R10
		st.second[drs_pkg::B1_LOCK] = ev.write_lock_in & ev.write_cmd; // R11
		st.second[drs_pkg::B1_MARK] = ev.no_id_after_two_markers | ev.no_data_mark; // R12
		st.third[drs_pkg::B2_CTRL]  = (ev.read_normal_cmd & ev.saw_deleted_mark)
			| (ev.read_deleted_cmd & ev.saw_normal_mark); // R13
		st.third[drs_pkg::B2_PCRC]  = ev.data_crc_fail; // R14
		st.third[drs_pkg::B2_TRK]   = track_diff; // R15
		st.third[drs_pkg::B2_BAD]   = track_diff & (ev.id_track == drs_pkg::BAD_TRACK_ID); // R16
		st.third[drs_pkg::B2_PMARK] = ev.no_data_mark; // R17
		abnormal = (|st.second) | (|st.third) | ev.recal_no_outer | ev.relseek_overstep;
		if (ev.fatal_invalid)
			code = drs_pkg::TC_INVALID; // R3
		else if (ev.fatal_polling)
			code = drs_pkg::TC_POLLING; // R3
		else if (started & abnormal)
			code = drs_pkg::TC_ABNORMAL; // R2
		st.first[drs_pkg::B0_TC_HI:drs_pkg::B0_TC_LO] = code; // R2
		st.first[drs_pkg::B0_SEEK]  = ev.seek_done; // R4
		st.first[drs_pkg::B0_FAULT] = ev.recal_no_outer | ev.relseek_overstep; // R5
		st.first[drs_pkg::B0_HEAD]  = ev.head; // R6
		st.first[drs_pkg::B0_UNIT_HI:drs_pkg::B0_UNIT_LO] = ev.unit_select; // R6
	end
endmodule

// File: rtl/drs_result_status.sv
// Result status capture and sequential data register readout
`timescale 1ns/10ps
module drs_result_status
(
	input  wire logic            sys_clk,
	input  wire logic            reset_n,
	input  wire logic            cmd_done,
	input  wire logic            cmd_started,
	input  drs_pkg::drs_events_t events,
	input  wire logic            data_rd,
	output logic [7:0]           data_out,
	output logic                 result_active,
	output logic                 result_last
);
	drs_pkg::drs_status_t enc;
	drs_pkg::drs_status_t cap_q, cap_d;
	drs_pkg::drs_state_t  state_q, state_d;
	logic [1:0]           idx_q, idx_d;
	logic [7:0]           data_q, data_d;
	logic                 last_q, last_d;
	logic                 active_d;

	drs_encode u_enc
	(
		.ev      (events),
		.started (cmd_started),
		.st      (enc)
	);

	function automatic logic [7:0] pick(input drs_pkg::drs_status_t s, input logic [1:0] i);
		unique case (i)
			2'h0: pick = s.first;
			2'h1: pick = s.second;
			default: pick = s.third;
		endcase
	endfunction

	always_comb
	begin
		state_d = state_q;
		cap_d   = cap_q;
		idx_d   = idx_q;
		data_d  = data_q;
		last_d  = last_q;
		unique case (state_q)
			drs_pkg::ST_IDLE:
			begin
				if (cmd_done)
				begin
					cap_d   = enc; // R19
					idx_d   = drs_pkg::IDX_FIRST;
					data_d  = pick(enc, drs_pkg::IDX_FIRST); // R1
					last_d  = 1'b0;
					state_d = drs_pkg::ST_RESULT;
				end
			end
			drs_pkg::ST_RESULT:
			begin
				// New terminations ignored until host drains all bytes
				if (data_rd)
				begin
					if (idx_q == drs_pkg::NUM_BYTES - 2'h1)
					begin
						state_d = drs_pkg::ST_IDLE; // R19
						data_d  = 8'h00;
						last_d  = 1'b0;
					end
					else
					begin
						idx_d  = idx_q + 2'h1;
						data_d = pick(cap_q, idx_q + 2'h1); // R1
						last_d = (idx_q + 2'h1) == (drs_pkg::NUM_BYTES - 2'h1);
					end
				end
			end
			default:
				state_d = drs_pkg::ST_IDLE;
		endcase
		// Flag follows the next state so it rises with the first byte
		active_d = (state_d == drs_pkg::ST_RESULT);
	end

	always_ff @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			state_q <= drs_pkg::ST_IDLE;
			cap_q   <= '0;
			idx_q   <= 2'h0;
			data_q  <= 8'h00;
			last_q  <= 1'b0;
		end
		else
		begin
			state_q <= state_d;
			cap_q   <= cap_d;
			idx_q   <= idx_d;
			data_q  <= data_d;
			last_q  <= last_d;
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
			result_active <= 1'b0;
		else
			result_active <= active_d;
	end

	assign data_out    = data_q;
	assign result_last = last_q;
endmodule

// File: test/drs_result_status_sva.sv
// Port assertions for the result status encoder
`timescale 1ns/10ps
module drs_result_status_sva
(
	input wire logic            sys_clk,
	input wire logic            reset_n,
	input wire logic            cmd_done,
	input wire logic            cmd_started,
	input drs_pkg::drs_events_t events,
	input wire logic            data_rd,
	input wire logic [7:0]      data_out,
	input wire logic            result_active,
	input wire logic            result_last
);
	default clocking dc @(posedge sys_clk); endclocking
	default disable iff (!reset_n);
	sequence cap_s;
		!result_active && cmd_done;
	endsequence
	sequence rd_s;
		result_active && data_rd;
	endsequence
	enter_phase_a: assert property (cap_s |=> result_active && !result_last)
		else $error("no result phase");
	code_invalid_a: assert property ((cap_s and events.fatal_invalid) |=> data_out[7:6] == 2'h2)
		else $error("bad invalid code");
	seek_bit_a: assert property (cap_s |=> data_out[5] == $past(events.seek_done))
		else $error("bad seek bit");
	head_unit_a: assert property (cap_s |=> data_out[3:0] == {1'b0, $past(events.head), $past(events.unit_select)})
		else $error("bad head or unit");
	second_byte_a: assert property (cap_s ##1 rd_s |=> !result_last && data_out[6] == 1'b0 && data_out[3] == 1'b0)
		else $error("bad second byte");
	read_walk_a: assert property (cap_s ##1 rd_s ##1 rd_s |=> result_last && data_out[7] == 1'b0)
		else $error("third byte not last");
	third_byte_a: assert property (result_last |-> data_out[3:2] == 2'h0)
		else $error("bad third byte");
	hold_byte_a: assert property (result_active && !data_rd |=> $stable(data_out) && result_active)
		else $error("byte not held");
	phase_end_a: assert property (result_last && data_rd |=> !result_active && data_out == 8'h00)
		else $error("phase did not end");
endmodule
bind drs_result_status drs_result_status_sva drs_result_status_sva_i (.sys_clk(sys_clk), .reset_n(reset_n),
	.cmd_done(cmd_done), .cmd_started(cmd_started), .events(events), .data_rd(data_rd), .data_out(data_out),
	.result_active(result_active), .result_last(result_last));

// File: test/drs_host_model.sv
// Host model draining result bytes, prompt or slow
`timescale 1ns/10ps
module drs_host_model
(
	input  wire logic       sys_clk,
	input  wire logic       result_active,
	input  wire logic [7:0] data_out,
	input  wire logic [3:0] gap,
	output logic            data_rd,
	output logic [23:0]     got
);
	logic [3:0] wait_q = 4'h0;
	initial data_rd = 1'b0;
	initial got = 24'h0;
	always @(posedge sys_clk)
		if (data_rd && result_active)
			got <= {got[15:0], data_out};
	always @(negedge sys_clk)
	begin
		data_rd <= result_active && (data_rd ? gap == 4'h0 : wait_q >= gap);
		wait_q <= (!result_active || data_rd) ? 4'h0 : wait_q + 4'h1;
	end
endmodule

// File: test/drs_result_status_tb.sv
// Self-checking bench for the result status encoder
`timescale 1ns/10ps
module drs_result_status_tb;
	logic sys_clk = 1'b0, reset_n = 1'b0, cmd_done = 1'b0, data_rd, result_active, result_last;
	logic [7:0] data_out;
	logic [3:0] gap = 4'h0;
	logic cmd_started = 1'b1;
	logic [23:0] got;
	drs_pkg::drs_events_t events = '0;
	int fails = 0, total_checks = 0;
	// Events beside the three expected bytes
	logic [63:0] rows [21] = '{64'h2600000000_260000, 64'h8100000000_810000, 64'h4000000000_C00000,
		64'h1000000000_500000, 64'h0800000000_500000, 64'h0080000000_408000, 64'h0040000000_408000,
		64'h0020000000_402000, 64'h0010000000_402020, 64'h0008000000_401000, 64'h0004000000_400400,
		64'h0002000000_400400, 64'h0001000000_400400, 64'h0000C00000_400200, 64'h0000800000_000000,
		64'h0000200000_400100, 64'h0000100000_400101, 64'h00000A0000_400040, 64'h0000050000_400040,
		64'h0000000503_400010, 64'h000000FF03_400012};
	always #20 sys_clk = ~sys_clk;
	drs_result_status drs_result_status_i (.sys_clk(sys_clk), .reset_n(reset_n), .cmd_done(cmd_done),
		.cmd_started(cmd_started), .events(events), .data_rd(data_rd), .data_out(data_out),
		.result_active(result_active), .result_last(result_last));
	drs_host_model drs_host_model_i (.sys_clk(sys_clk), .result_active(result_active), .data_out(data_out),
		.gap(gap), .data_rd(data_rd), .got(got));
	task automatic check(input string what, input logic [24:0] seen, input logic [24:0] exp);
	begin
		total_checks++;
		if (seen !== exp)
		begin
			fails++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	end
	endtask
	task end_sim;
	begin
		if (fails == 0 && total_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	end
	endtask
	// Events are scrambled after capture, so bytes must come from the capture
	task automatic run(input logic [63:0] r, input int hold);
	begin
		@(negedge sys_clk);
		events = r[63:24];
		cmd_done = 1'b1;
		@(negedge sys_clk);
		events = '1;
		repeat (hold - 1) @(negedge sys_clk);
		cmd_done = 1'b0;
		for (int i = 0; i < 60 && result_active; i++) @(negedge sys_clk);
		check("bytes", {got, result_active}, {r[23:0], 1'b0});
	end
	endtask
	initial
	begin
		repeat (2) @(negedge sys_clk);
		reset_n = 1'b1;
		check("reset", 25'({data_out, result_active, result_last}), 25'h0);
		foreach (rows[i])
			run(rows[i], 1);
		gap = 4'h3;
		run(rows[8], 3);
		// Errors without a started execution keep the normal code
		cmd_started = 1'b0;
		run({rows[9][63:24], 24'h001000}, 1);
		cmd_started = 1'b1;
		cmd_done = 1'b1;
		@(negedge sys_clk);
		cmd_done = 1'b0;
		reset_n = 1'b0;
		#1 check("mid reset", 25'({data_out, result_active, result_last}), 25'h0);
		@(negedge sys_clk);
		reset_n = 1'b1;
		run(rows[0], 1);
		end_sim;
	end
	initial
	begin
		#400000;
		fails++;
		end_sim;
	end
endmodule
